//--- hw/tc_timer.sv
// eight-bit timer/counter with compare units, axi4-lite registers and crystal clocking
//
// Decided for this implementation: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - zero count raises the bottom indication
// - count of all ones is maximum
// - top is maximum or compare A by mode
// - counter and both compares are eight bits
// - flags visible, each gated by mask bit
// - sources: overflow, compare A, compare B
// - clock select zero stops the counter
// - tick comes from system clock by default
// - async select takes crystal pin clock
// - each tick clears, increments or decrements
// - counter readable and writable at any time
// - counter write beats same-cycle count or clear
// - three-bit mode split across control A, B
// - continuous compare sets flag on match
// - compare results drive two wave outputs
// - overflow flag set per mode, requestable
// - power gate bit one enables the timer
// - compares double buffered only in PWM
// - normal mode wraps, overflow at zero
// - clear-on-match mode resets on compare A
module tc_timer (
	// clock, enable and reset
	input  wire logic        clk,
	input  wire logic        ce,
	input  wire logic        rst_n,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// crystal pins
	input  wire logic        crystal_pin_in,
	output logic             crystal_pin_out,
	// waveform and indications
	output logic             wave_out_a,
	output logic             wave_out_b,
	output logic             wave_bottom,
	output logic             wave_max,
	output logic             wave_top,
	output logic [2:0]       irq_req
);
	//////////////////////////////////////////////////////////////////////////
	// registers
	logic [1:0]            timer_ctrl_a;
	logic [3:0]            timer_ctrl_b;
	logic [7:0]            counter_value;
	logic [1:0][7:0]       cmp_buf;
	logic [1:0][7:0]       cmp_act;
	logic [2:0]            timer_flag_reg;
	logic [2:0]            timer_mask_reg;
	logic                  async_clock_select;
	logic                  timer_power_gate;
	tc_pkg::tc_pend_t [2:0] pend;
	tc_pkg::tc_dir_t       dir;
	logic                  block;
	logic [1:0]            wave_q;

	// bus state
	logic                  aw_held;
	logic                  w_held;
	logic [7:0]            aw_addr;
	logic [7:0]            w_data;
	logic                  w_strb0;

	//////////////////////////////////////////////////////////////////////////
	// crystal pin and tick source
	wire  xtal_level;
	wire  xtal_rise;
	wire  timer_tick;
	wire  src_edge;

	tc_pin_sync u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.pin_in (crystal_pin_in),
		.level  (xtal_level),
		.rise   (xtal_rise)
	);

	assign src_edge = async_clock_select ? xtal_rise : 1'b1;

	tc_prescaler u_pre (
		.clk                (clk),
		.rst_n              (rst_n),
		.ce                 (ce),
		.run                (timer_power_gate),
		.src_edge           (src_edge),
		.clock_select_field (timer_ctrl_b[tc_pkg::CTRL_B_CS_LSB +: 3]),
		.timer_tick         (timer_tick)
	);

	//////////////////////////////////////////////////////////////////////////
	// bus decode
	wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
	wire rd_fire = s_axi_arvalid & s_axi_arready;
	wire [7:0] wa = {aw_addr[7:2], 2'b00};
	wire [7:0] ra = {s_axi_araddr[7:2], 2'b00};
	wire wr_en = wr_fire & w_strb0;
	wire wr_ctrl_a = wr_en & (wa == tc_pkg::OFF_CTRL_A);
	wire wr_ctrl_b = wr_en & (wa == tc_pkg::OFF_CTRL_B);
	wire wr_flag   = wr_en & (wa == tc_pkg::OFF_FLAG);
	wire wr_mask   = wr_en & (wa == tc_pkg::OFF_MASK);
	wire wr_async  = wr_en & (wa == tc_pkg::OFF_ASYNC);
	wire wr_power  = wr_en & (wa == tc_pkg::OFF_POWER);
	wire [2:0] wr_hit = {wr_en & (wa == tc_pkg::OFF_CMP_B),
	                     wr_en & (wa == tc_pkg::OFF_CMP_A),
	                     wr_en & (wa == tc_pkg::OFF_COUNT)};
	wire wa_ok = (wa <= tc_pkg::OFF_POWER);
	wire ra_ok = (ra <= tc_pkg::OFF_POWER);
	wire [2:0] busy = {pend[2].valid, pend[1].valid, pend[0].valid};

	wire [7:0] rd_mux =
		(ra == tc_pkg::OFF_CTRL_A) ? {6'h00, timer_ctrl_a} :
		(ra == tc_pkg::OFF_CTRL_B) ? {4'h0, timer_ctrl_b} :
		(ra == tc_pkg::OFF_COUNT)  ? counter_value :
		(ra == tc_pkg::OFF_CMP_A)  ? cmp_buf[0] :
		(ra == tc_pkg::OFF_CMP_B)  ? cmp_buf[1] :
		(ra == tc_pkg::OFF_FLAG)   ? {5'h00, timer_flag_reg} :
		(ra == tc_pkg::OFF_MASK)   ? {5'h00, timer_mask_reg} :
		(ra == tc_pkg::OFF_ASYNC)  ? {4'h0, busy, async_clock_select} :
		(ra == tc_pkg::OFF_POWER)  ? {7'h00, timer_power_gate} :
		8'h00;

	// a frozen slave must not complete a handshake that its registers cannot take
	assign s_axi_awready = ce & ~aw_held & ~s_axi_bvalid;
	assign s_axi_wready  = ce & ~w_held & ~s_axi_bvalid;
	assign s_axi_arready = ce & ~s_axi_rvalid;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 8'h00;
			w_data       <= 8'h00;
			w_strb0      <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= tc_pkg::RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= tc_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_held  <= 1'b1;
				w_data  <= s_axi_wdata[7:0];
				w_strb0 <= s_axi_wstrb[0];
			end
			else if (wr_fire)
				w_held <= 1'b0;
			if (wr_fire)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wa_ok ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (rd_fire)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_mux};
				s_axi_rresp  <= ra_ok ? tc_pkg::RESP_OKAY : tc_pkg::RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// parked writes toward the crystal domain
	wire [2:0]      commit;
	wire [2:0][7:0] commit_data;

	genvar t;
	generate
		for (t = 0; t < 3; t++)
		begin : g_pend
			// direct in system clocking; in crystal clocking held until the next crystal edge
			wire direct = wr_hit[t] & ~async_clock_select;
			assign commit[t] = direct | (pend[t].valid & (xtal_rise | ~async_clock_select));
			assign commit_data[t] = direct ? w_data : pend[t].data;
			always_ff @(posedge clk)
			begin
				if (!rst_n)
					pend[t] <= '0;
				else if (ce)
				begin
					if (wr_hit[t] & async_clock_select)
						pend[t] <= '{valid: 1'b1, data: w_data};
					else if (commit[t])
						pend[t].valid <= 1'b0;
				end
			end
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////
	// counting sequence
	tc_pkg::tc_wave_t wave_mode_field;
	assign wave_mode_field = tc_pkg::tc_wave_t'({timer_ctrl_b[tc_pkg::CTRL_B_WAVE2], timer_ctrl_a});
	wire is_pwm   = wave_mode_field[0];
	wire is_fast  = wave_mode_field[0] & wave_mode_field[1];
	wire top_is_a = (wave_mode_field == tc_pkg::TC_WAVE_CTC) | (wave_mode_field[2] & wave_mode_field[0]);
	wire [7:0] top_val = top_is_a ? cmp_act[0] : tc_pkg::CNT_MAX;
	wire at_max = (counter_value == tc_pkg::CNT_MAX);
	wire at_top = (counter_value == top_val);
	wire top_tick = timer_tick & at_top;

	logic [7:0]      next_counter;
	tc_pkg::tc_dir_t next_dir;
	logic            ovf_event;

	always_comb
	begin
		next_counter = counter_value;
		next_dir     = dir;
		ovf_event    = 1'b0;
		if (timer_tick)
		begin
			case (wave_mode_field)
				tc_pkg::TC_WAVE_CTC:
				begin
					next_counter = (counter_value == cmp_act[0]) ? tc_pkg::CNT_BOTTOM : counter_value + 8'h01;
					ovf_event    = at_max & (counter_value != cmp_act[0]);
				end
				tc_pkg::TC_WAVE_FAST_MAX, tc_pkg::TC_WAVE_FAST_A:
				begin
					next_counter = at_top ? tc_pkg::CNT_BOTTOM : counter_value + 8'h01;
					ovf_event    = at_top;
				end
				tc_pkg::TC_WAVE_PC_MAX, tc_pkg::TC_WAVE_PC_A:
				begin
					case (dir)
						tc_pkg::TC_DIR_UP:
						begin
							next_counter = at_top ? counter_value - 8'h01 : counter_value + 8'h01;
							next_dir     = at_top ? tc_pkg::TC_DIR_DOWN : tc_pkg::TC_DIR_UP;
						end
						default:
						begin
							next_counter = (counter_value == tc_pkg::CNT_BOTTOM) ? counter_value + 8'h01
							                                                    : counter_value - 8'h01;
							next_dir     = (counter_value == tc_pkg::CNT_BOTTOM) ? tc_pkg::TC_DIR_UP : dir;
							ovf_event    = (counter_value == tc_pkg::CNT_BOTTOM);
						end
					endcase
				end
				default:
				begin
					next_counter = counter_value + 8'h01;
					ovf_event    = at_max;
				end
			endcase
		end
		if (commit[0])
			next_counter = commit_data[0];
	end

	// a counter write masks the compare at the following tick
	wire [1:0] match = {2{timer_tick & ~block}} & {counter_value == cmp_act[1], counter_value == cmp_act[0]};
	wire [2:0] flag_set = {match, ovf_event};
	wire [2:0] flag_clr = wr_flag ? w_data[2:0] : 3'h0;
	wire [2:0] next_flag = (timer_flag_reg & ~flag_clr) | flag_set;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			counter_value  <= tc_pkg::RST_REG8;
			dir            <= tc_pkg::TC_DIR_UP;
			block          <= 1'b0;
			timer_flag_reg <= tc_pkg::RST_FLAGS;
			irq_req        <= tc_pkg::RST_FLAGS;
			wave_bottom    <= 1'b1;
			wave_max       <= 1'b0;
			wave_top       <= 1'b0;
		end
		else if (ce)
		begin
			counter_value  <= next_counter;
			dir            <= (wave_mode_field[0] & ~wave_mode_field[1]) ? next_dir : tc_pkg::TC_DIR_UP;
			block          <= commit[0] | (block & ~timer_tick);
			timer_flag_reg <= next_flag;
			irq_req        <= timer_flag_reg & timer_mask_reg;
			wave_bottom    <= (next_counter == tc_pkg::CNT_BOTTOM);
			wave_max       <= (next_counter == tc_pkg::CNT_MAX);
			wave_top       <= (next_counter == top_val);
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// compare units and wave outputs
	genvar c;
	generate
		for (c = 0; c < 2; c++)
		begin : g_cmp
			always_ff @(posedge clk)
			begin
				if (!rst_n)
				begin
					cmp_buf[c] <= tc_pkg::RST_REG8;
					cmp_act[c] <= tc_pkg::RST_REG8;
					wave_q[c]  <= 1'b0;
				end
				else if (ce)
				begin
					if (commit[c+1])
						cmp_buf[c] <= commit_data[c+1];
					// pwm waits for top so no pulse comes out odd-length
					if (!is_pwm)
						cmp_act[c] <= commit[c+1] ? commit_data[c+1] : cmp_buf[c];
					else if (top_tick)
						cmp_act[c] <= cmp_buf[c];
					if (!is_pwm)
						wave_q[c] <= wave_q[c] ^ match[c];
					else if (is_fast)
					begin
						if (match[c])
							wave_q[c] <= 1'b0;
						else if (top_tick)
							wave_q[c] <= 1'b1;
					end
					else if (match[c])
						wave_q[c] <= (dir == tc_pkg::TC_DIR_DOWN);
				end
			end
		end
	endgenerate

	assign wave_out_a = wave_q[0];
	assign wave_out_b = wave_q[1];

	//////////////////////////////////////////////////////////////////////////
	// control, mask, async and power registers
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			timer_ctrl_a       <= 2'h0;
			timer_ctrl_b       <= 4'h0;
			timer_mask_reg     <= tc_pkg::RST_FLAGS;
			async_clock_select <= 1'b0;
			timer_power_gate   <= 1'b0;
			crystal_pin_out    <= 1'b1;
		end
		else if (ce)
		begin
			if (wr_ctrl_a)
				timer_ctrl_a <= w_data[1:0];
			if (wr_ctrl_b)
				timer_ctrl_b <= w_data[3:0];
			if (wr_mask)
				timer_mask_reg <= w_data[2:0];
			if (wr_async)
				async_clock_select <= w_data[tc_pkg::ASYNC_SEL_BIT];
			if (wr_power)
				timer_power_gate <= w_data[tc_pkg::POWER_GATE_BIT];
			// inverting amplifier side of the oscillator
			crystal_pin_out <= ~xtal_level;
		end
	end
endmodule // tc_timer
`default_nettype wire

//--- hw/tc_pkg.sv
// constants, types and register map of the eight-bit timer/counter
package tc_pkg;

	//////////////////////////////////////////////////////////////////////////
	// register byte offsets on the axi4-lite slave
	localparam logic [7:0] OFF_CTRL_A  = 8'h00;
	localparam logic [7:0] OFF_CTRL_B  = 8'h04;
	localparam logic [7:0] OFF_COUNT   = 8'h08;
	localparam logic [7:0] OFF_CMP_A   = 8'h0c;
	localparam logic [7:0] OFF_CMP_B   = 8'h10;
	localparam logic [7:0] OFF_FLAG    = 8'h14;
	localparam logic [7:0] OFF_MASK    = 8'h18;
	localparam logic [7:0] OFF_ASYNC   = 8'h1c;
	localparam logic [7:0] OFF_POWER   = 8'h20;

	//////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int unsigned CTRL_B_CS_LSB   = 0;
	localparam int unsigned CTRL_B_WAVE2    = 3;
	localparam int unsigned FLAG_OVF        = 0;
	localparam int unsigned FLAG_CMP_A      = 1;
	localparam int unsigned ASYNC_SEL_BIT   = 0;
	localparam int unsigned ASYNC_BUSY_LSB  = 1;
	localparam int unsigned POWER_GATE_BIT  = 0;

	// reset values
	localparam logic [7:0] RST_REG8   = 8'h00;
	localparam logic [2:0] RST_FLAGS  = 3'h0;

	// count extremes
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [7:0] CNT_MAX    = 8'hff;

	//////////////////////////////////////////////////////////////////////////
	// waveform modes
	typedef enum logic [2:0] {
		TC_WAVE_NORMAL  = 3'h0,
		TC_WAVE_PC_MAX  = 3'h1,
		TC_WAVE_CTC     = 3'h2,
		TC_WAVE_FAST_MAX= 3'h3,
		TC_WAVE_RSV4    = 3'h4,
		TC_WAVE_PC_A    = 3'h5,
		TC_WAVE_RSV6    = 3'h6,
		TC_WAVE_FAST_A  = 3'h7
	} tc_wave_t;

	// count direction of the phase correct sequence
	typedef enum logic {
		TC_DIR_UP   = 1'b0,
		TC_DIR_DOWN = 1'b1
	} tc_dir_t;

	// clock select codes and their prescaler tap masks
	localparam logic [2:0] CS_STOP    = 3'h0;
	localparam logic [2:0] CS_DIV1    = 3'h1;
	localparam logic [2:0] CS_DIV8    = 3'h2;
	localparam logic [2:0] CS_DIV32   = 3'h3;
	localparam logic [2:0] CS_DIV64   = 3'h4;
	localparam logic [2:0] CS_DIV128  = 3'h5;
	localparam logic [2:0] CS_DIV256  = 3'h6;
	localparam logic [9:0] MASK_DIV1   = 10'h000;
	localparam logic [9:0] MASK_DIV8   = 10'h007;
	localparam logic [9:0] MASK_DIV32  = 10'h01f;
	localparam logic [9:0] MASK_DIV64  = 10'h03f;
	localparam logic [9:0] MASK_DIV128 = 10'h07f;
	localparam logic [9:0] MASK_DIV256 = 10'h0ff;
	localparam logic [9:0] MASK_DIV1024= 10'h3ff;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// software write parked until the crystal domain can take it
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} tc_pend_t;

endpackage

//--- hw/tc_pin_sync.sv
// crystal pin synchroniser with rising edge detection
`timescale 1ns/100ps
`default_nettype none
module tc_pin_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	// pin
	input  wire logic pin_in,
	// synchronised level and its rising edge
	output logic      level,
	output logic      rise
);
	logic meta;
	logic prev;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			meta  <= 1'b0;
			level <= 1'b0;
			prev  <= 1'b0;
		end
		else if (ce)
		begin
			meta  <= pin_in;
			level <= meta;
			prev  <= level;
		end
	end

	// edge taken from the second and third stages only
	assign rise = ce & level & ~prev;
endmodule // tc_pin_sync
`default_nettype wire

//--- hw/tc_prescaler.sv
// ten-bit prescaler turning source edges into timer ticks
`timescale 1ns/100ps
`default_nettype none
module tc_prescaler (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// control
	input  wire logic       run,
	input  wire logic       src_edge,
	input  wire logic [2:0] clock_select_field,
	// tick out
	output logic            timer_tick
);
	logic [9:0] pre;
	wire  [9:0] tap_mask;
	wire        stopped;

	assign tap_mask =
		(clock_select_field == tc_pkg::CS_DIV1)   ? tc_pkg::MASK_DIV1   :
		(clock_select_field == tc_pkg::CS_DIV8)   ? tc_pkg::MASK_DIV8   :
		(clock_select_field == tc_pkg::CS_DIV32)  ? tc_pkg::MASK_DIV32  :
		(clock_select_field == tc_pkg::CS_DIV64)  ? tc_pkg::MASK_DIV64  :
		(clock_select_field == tc_pkg::CS_DIV128) ? tc_pkg::MASK_DIV128 :
		(clock_select_field == tc_pkg::CS_DIV256) ? tc_pkg::MASK_DIV256 :
		tc_pkg::MASK_DIV1024;
	assign stopped = (clock_select_field == tc_pkg::CS_STOP);

	// free running while powered; it does not restart on a clock select change
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			pre <= 10'h000;
		else if (ce)
		begin
			if (!run)
				pre <= 10'h000;
			else if (src_edge)
				pre <= pre + 10'h001;
		end
	end

	assign timer_tick = ce & run & src_edge & ~stopped & ((pre & tap_mask) == tap_mask);
endmodule // tc_prescaler
`default_nettype wire

//--- tb/tc_sva.sv
// assertion checker for the timer's bus and indication ports
`timescale 1ns/100ps
`default_nettype none
module tc_sva (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// write side
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// read side
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// indications
	input wire logic        wave_bottom,
	input wire logic        wave_max
);
	logic [7:0] last_aw;
	logic [7:0] last_ar;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	//////////////////////////////////////////////////////////////////////////
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// each response is judged against the address of its own request
	always_ff @(posedge clk)
	begin
		if (s_axi_awvalid && s_axi_awready)
			last_aw <= s_axi_awaddr;
		if (s_axi_arvalid && s_axi_arready)
			last_ar <= s_axi_araddr;
	end
	//////////////////////////////////////////////////////////////////////////
	wr_latency_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	wr_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
		((last_aw > 8'h23) ? tc_pkg::RESP_SLVERR : tc_pkg::RESP_OKAY)) else $error("write response code wrong");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	rd_latency_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data late");
	rd_resp_a: assert property (s_axi_rvalid |-> s_axi_rresp == ((last_ar > 8'h23) ? tc_pkg::RESP_SLVERR :
		tc_pkg::RESP_OKAY) && (last_ar <= 8'h23 || s_axi_rdata == 32'h0)) else $error("read response wrong");
	rd_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data wider than a byte");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	ends_apart_a: assert property (!(wave_bottom && wave_max))
		else $error("bottom and maximum together");
endmodule // tc_sva

bind tc_timer tc_sva u_sva (.*);
`default_nettype wire

//--- tb/tc_xtal_model.sv
// watch crystal oscillator model driving the crystal pin
`timescale 1ns/100ps
`default_nettype none
module tc_xtal_model #(
	parameter int HALF = 8
) (
	// clock and control
	input wire logic   clk,
	input wire logic   run,
	// oscillator and its rising edge count
	output logic        osc,
	output logic [15:0] rises
);
	int cnt;
	initial
	begin
		osc = 1'b0;
		rises = 16'h0;
		cnt = 0;
	end
	// a stopped crystal holds its level, so no edge escapes between bursts
	always @(posedge clk)
	begin
		if (run && cnt == HALF - 1)
		begin
			cnt <= 0;
			osc <= !osc;
			if (!osc)
				rises <= rises + 16'h1;
		end
		else if (run)
			cnt <= cnt + 1;
	end
endmodule // tc_xtal_model
`default_nettype wire

//--- tb/tb.sv
// self-checking testbench of the eight-bit timer/counter
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic        clk, ce, rst_n, xtal_run;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic   crystal_pin_in, crystal_pin_out, wave_out_a, wave_out_b, wave_bottom, wave_max, wave_top;
	wire logic [2:0]  irq_req;
	wire logic [15:0] rises;
	int          bad_count, checked;
	logic [7:0]  v;
	tc_timer u_dut (.*);
	tc_xtal_model #(.HALF(8)) u_xtal (.clk(clk), .run(xtal_run), .osc(crystal_pin_in), .rises(rises));
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	//////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_rng(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
		checked++;
		if (((got >= lo) && (got <= hi)) !== 1'b1)
		begin
			bad_count++;
			$display("Error %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	task automatic hang(input string what);
		bad_count++;
		$display("Error %s expected handshake seen timeout", what);
		tally_and_finish;
	endtask
	function automatic logic [7:0] exp_resp(input logic [7:0] a);
		return {6'h0, (a > 8'h23) ? tc_pkg::RESP_SLVERR : tc_pkg::RESP_OKAY};
	endfunction
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	// bready and rready stay high, so a new request never collides with a release
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_go, w_go, b_go;
		logic [1:0] resp;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		repeat (100)
		begin
			@(negedge clk);
			aw_go = s_axi_awvalid & s_axi_awready;
			w_go = s_axi_wvalid & s_axi_wready;
			b_go = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge clk);
			if (aw_go)
				s_axi_awvalid <= 1'b0;
			if (w_go)
				s_axi_wvalid <= 1'b0;
			if (b_go)
			begin
				check8("bresp", exp_resp(a), {6'h0, resp});
				return;
			end
		end
		hang("write");
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic ar_go, r_go;
		logic [31:0] data;
		logic [1:0] resp;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		repeat (100)
		begin
			@(negedge clk);
			ar_go = s_axi_arvalid & s_axi_arready;
			r_go = s_axi_rvalid;
			data = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge clk);
			if (ar_go)
				s_axi_arvalid <= 1'b0;
			if (r_go)
			begin
				d = data[7:0];
				check8("rresp", exp_resp(a), {6'h0, resp});
				return;
			end
		end
		hang("read");
	endtask
	task automatic pins(input logic [7:0] irq_exp);
		@(negedge clk);
		check8("irq_req", irq_exp, {5'h0, irq_req});
		@(posedge clk);
	endtask
	//////////////////////////////////////////////////////////////////////////
	task automatic test_reset;
		for (int i = 0; i < 9; i++)
		begin
			rd(8'(i * 4), v);
			check8("reset value", 8'h00, v);
		end
		rd(8'h24, v);
		check8("unmapped", 8'h00, v);
		@(negedge clk);
		check8("edge outs", 8'h09, {4'h0, crystal_pin_out, wave_top, wave_max, wave_bottom});
		pins(8'h00);
		$display("test reset done");
	endtask
	task automatic test_gate;
		wr(tc_pkg::OFF_COUNT, 8'h33);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_DIV1});
		idle(20);
		rd(tc_pkg::OFF_COUNT, v);
		check8("gated count", 8'h33, v);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_STOP});
		wr(tc_pkg::OFF_POWER, 8'h01);
		idle(20);
		rd(tc_pkg::OFF_COUNT, v);
		check8("stopped count", 8'h33, v);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_DIV1});
		rd(tc_pkg::OFF_COUNT, v);
		chk_rng("running count", 8'h34, 8'h40, v);
		// a low clock enable must hold the count through thirty edges
		ce <= 1'b0;
		idle(30);
		ce <= 1'b1;
		rd(tc_pkg::OFF_COUNT, v);
		chk_rng("frozen count", 8'h35, 8'h40, v);
		wr(tc_pkg::OFF_COUNT, 8'h80);
		rd(tc_pkg::OFF_COUNT, v);
		chk_rng("written count", 8'h80, 8'h88, v);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_STOP});
		$display("test gate done");
	endtask
	task automatic test_normal;
		wr(tc_pkg::OFF_FLAG, 8'h07);
		wr(tc_pkg::OFF_CMP_A, 8'h10);
		wr(tc_pkg::OFF_CMP_B, 8'h20);
		wr(tc_pkg::OFF_COUNT, 8'h00);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_DIV1});
		// one wrap plus a few ticks, short of the second match at 0x10
		idle(260);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_STOP});
		rd(tc_pkg::OFF_COUNT, v);
		chk_rng("wrapped count", 8'h01, 8'h0f, v);
		rd(tc_pkg::OFF_FLAG, v);
		check8("flags", 8'h07, v);
		@(negedge clk);
		check8("wave outs", 8'h03, {6'h0, wave_out_b, wave_out_a});
		@(posedge clk);
		wr(tc_pkg::OFF_MASK, 8'h07);
		pins(8'h07);
		wr(tc_pkg::OFF_FLAG, 8'h01);
		pins(8'h06);
		wr(tc_pkg::OFF_MASK, 8'h02);
		pins(8'h02);
		$display("test normal done");
	endtask
	task automatic test_modes;
		logic [7:0] ma[3] = '{8'h02, 8'h03, 8'h01};
		logic [7:0] mb[3] = '{8'h01, 8'h09, 8'h0a};
		logic [7:0] ovf[3] = '{8'h00, 8'h01, 8'h01};
		// last pass: phase correct up to compare A, divided by eight
		for (int i = 0; i < 3; i++)
		begin
			wr(tc_pkg::OFF_CTRL_B, 8'h00);
			wr(tc_pkg::OFF_CTRL_A, 8'h00);
			wr(tc_pkg::OFF_CMP_A, 8'h05);
			wr(tc_pkg::OFF_CTRL_A, ma[i]);
			wr(tc_pkg::OFF_COUNT, 8'h00);
			wr(tc_pkg::OFF_FLAG, 8'h07);
			wr(tc_pkg::OFF_CTRL_B, mb[i]);
			idle(100);
			wr(tc_pkg::OFF_CTRL_B, mb[i] & 8'h08);
			rd(tc_pkg::OFF_COUNT, v);
			chk_rng("count below top", 8'h00, 8'h05, v);
			rd(tc_pkg::OFF_FLAG, v);
			check8("overflow by mode", ovf[i], v & 8'h01);
		end
		$display("test modes done");
	endtask
	task automatic test_async;
		wr(tc_pkg::OFF_CTRL_B, 8'h00);
		wr(tc_pkg::OFF_CTRL_A, 8'h00);
		wr(tc_pkg::OFF_ASYNC, 8'h01);
		wr(tc_pkg::OFF_COUNT, 8'h40);
		wr(tc_pkg::OFF_CTRL_B, {5'h0, tc_pkg::CS_DIV1});
		idle(40);
		rd(tc_pkg::OFF_ASYNC, v);
		check8("parked write", 8'h03, v);
		xtal_run <= 1'b1;
		for (int n = 0; n < 600 && rises < 16'd6; n++)
			@(posedge clk);
		if (rises < 16'd6)
			hang("crystal");
		xtal_run <= 1'b0;
		idle(40);
		rd(tc_pkg::OFF_ASYNC, v);
		check8("committed write", 8'h01, v);
		rd(tc_pkg::OFF_COUNT, v);
		chk_rng("crystal count", 8'h44, 8'h46, v);
		wr(tc_pkg::OFF_ASYNC, 8'h00);
		$display("test async done");
	endtask
	//////////////////////////////////////////////////////////////////////////
	initial
	begin
		{ce, s_axi_bready, s_axi_rready} = 3'h7;
		{rst_n, xtal_run, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		bad_count = 0;
		checked = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		test_reset;
		test_gate;
		test_normal;
		test_modes;
		test_async;
		tally_and_finish;
	end
endmodule // tb
`default_nettype wire
